// File: rtl/mfc_flow_ctrl.v
// Flow-control request logic: pause and priority pause frames, receive pause requests
// Function
// - Pause request valid from the client makes the MAC send one pause frame.
// - Pause value presented with the request becomes the frame's pause time field.
// - Priority request and acknowledge ports only work when priority flow control is built in.
// - Each of priorities 0 to 7 has its own receive pause request output.
// - A priority's quanta do not count down until its FIFO acknowledges.
// - A priority transmit request gives a priority frame at the next available point.
`timescale 1ns/1ps
`default_nettype none
`include "mfc_map.vh"

module mfc_flow_ctrl #(
  parameter PFC_EN = 1
) (
  input wire clk,
  input wire rstn,
  input wire pause_req_valid,
  input wire [`MFC_QW-1:0] pause_value,
  input wire [`MFC_NPRIO-1:0] tx_prio_pause_req_in,
  input wire [`MFC_QW-1:0] pfc_tx_quanta,
  output reg tx_fc_frame_valid,
  input wire tx_fc_frame_ready,
  output reg tx_fc_frame_kind,
  output reg [`MFC_QW-1:0] tx_fc_pause_time,
  output reg [`MFC_NPRIO-1:0] tx_fc_class_enable,
  input wire rx_pfc_frame_valid,
  input wire [`MFC_NPRIO-1:0] rx_pfc_class_enable,
  input wire [`MFC_QALL-1:0] rx_pfc_quanta,
  output wire [`MFC_NPRIO-1:0] rx_prio_pause_req_out,
  input wire [`MFC_NPRIO-1:0] rx_prio_pause_ack_in
);

  // Edge history, so a held request produces one frame and not a stream
  reg pause_prev_reg;
  reg [`MFC_NPRIO-1:0] prio_prev_reg;

  // Pending requests not yet handed to the transmit stream
  reg pause_pend_reg;
  reg pause_pend_next;
  reg [`MFC_QW-1:0] pause_val_reg;
  reg [`MFC_QW-1:0] pause_val_next;
  reg [`MFC_NPRIO-1:0] prio_pend_reg;
  reg [`MFC_NPRIO-1:0] prio_pend_next;

  // Next contents of the frame request stage
  reg frame_valid_next;
  reg frame_kind_next;
  reg [`MFC_QW-1:0] frame_time_next;
  reg [`MFC_NPRIO-1:0] frame_cev_next;

  wire pause_edge;
  wire [`MFC_NPRIO-1:0] prio_edge;
  wire [`MFC_NPRIO-1:0] prio_gate;
  wire stage_free;
  wire take_pause;
  wire take_prio;
  wire [`MFC_NPRIO-1:0] prio_load;

  // Priority ports are ignored when the option is not built in
  assign prio_gate = (PFC_EN != 0) ? 8'hFF : `MFC_V_ZERO;

  assign pause_edge = pause_req_valid & ~pause_prev_reg;
  assign prio_edge = tx_prio_pause_req_in & ~prio_prev_reg & prio_gate;

  // Stage may load when empty or when the transmitter takes its frame this cycle
  assign stage_free = ~tx_fc_frame_valid | tx_fc_frame_ready;

  // Plain pause goes first; priority frames follow on the next free slot
  assign take_pause = stage_free & pause_pend_reg;
  assign take_prio = stage_free & ~pause_pend_reg & (prio_pend_reg != `MFC_V_ZERO);

  // Pending bookkeeping; a new request in the cycle of hand-over is kept
  always @* begin
    pause_pend_next = pause_pend_reg;
    pause_val_next = pause_val_reg;
    prio_pend_next = prio_pend_reg;
    if (take_pause) begin
      pause_pend_next = 1'b0;
    end
    if (take_prio) begin
      prio_pend_next = `MFC_V_ZERO;
    end
    if (pause_edge) begin
      // Latest value wins if a second request comes before the first is handed to the frame stage
      pause_pend_next = 1'b1;
      pause_val_next = pause_value;
    end
    prio_pend_next = prio_pend_next | prio_edge;
  end

  // Frame request stage: holds its fields stable until taken
  always @* begin
    frame_valid_next = tx_fc_frame_valid;
    frame_kind_next = tx_fc_frame_kind;
    frame_time_next = tx_fc_pause_time;
    frame_cev_next = tx_fc_class_enable;
    if (stage_free) begin
      frame_valid_next = take_pause | take_prio;
      if (take_pause) begin
        frame_kind_next = `MFC_KIND_PAUSE;
        frame_time_next = pause_val_reg;
        frame_cev_next = `MFC_V_ZERO;
      end else if (take_prio) begin
        frame_kind_next = `MFC_KIND_PFC;
        frame_time_next = pfc_tx_quanta;
        frame_cev_next = prio_pend_reg;
      end
    end
  end

  // Transmit-side registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pause_prev_reg <= 1'b0;
      prio_prev_reg <= `MFC_V_ZERO;
      pause_pend_reg <= 1'b0;
      pause_val_reg <= `MFC_Q_ZERO;
      prio_pend_reg <= `MFC_V_ZERO;
      tx_fc_frame_valid <= 1'b0;
      tx_fc_frame_kind <= `MFC_KIND_PAUSE;
      tx_fc_pause_time <= `MFC_Q_ZERO;
      tx_fc_class_enable <= `MFC_V_ZERO;
    end else begin
      pause_prev_reg <= pause_req_valid;
      prio_prev_reg <= tx_prio_pause_req_in;
      pause_pend_reg <= pause_pend_next;
      pause_val_reg <= pause_val_next;
      prio_pend_reg <= prio_pend_next;
      tx_fc_frame_valid <= frame_valid_next;
      tx_fc_frame_kind <= frame_kind_next;
      tx_fc_pause_time <= frame_time_next;
      tx_fc_class_enable <= frame_cev_next;
    end
  end

  // A received frame loads only the priorities it addresses; gated off without the option
  assign prio_load = {`MFC_NPRIO{rx_pfc_frame_valid}} & rx_pfc_class_enable & prio_gate;

  // One independent timer per receive priority; a FIFO that ignores the
  // handshake relies on its acknowledge being tied high
  // Priority 0 receive pause
  mfc_prio_pause u_prio0 (
    .clk(clk),
    .rstn(rstn),
    .load(prio_load[0]),
    .quanta(rx_pfc_quanta[0*`MFC_QW +: `MFC_QW]),
    .ack_in(rx_prio_pause_ack_in[0]),
    .req_out(rx_prio_pause_req_out[0])
  );

  // Priority 1 receive pause
  mfc_prio_pause u_prio1 (
    .clk(clk),
    .rstn(rstn),
    .load(prio_load[1]),
    .quanta(rx_pfc_quanta[1*`MFC_QW +: `MFC_QW]),
    .ack_in(rx_prio_pause_ack_in[1]),
    .req_out(rx_prio_pause_req_out[1])
  );

  // Priority 2 receive pause
  mfc_prio_pause u_prio2 (
    .clk(clk),
    .rstn(rstn),
    .load(prio_load[2]),
    .quanta(rx_pfc_quanta[2*`MFC_QW +: `MFC_QW]),
    .ack_in(rx_prio_pause_ack_in[2]),
    .req_out(rx_prio_pause_req_out[2])
  );

  // Priority 3 receive pause
  mfc_prio_pause u_prio3 (
    .clk(clk),
    .rstn(rstn),
    .load(prio_load[3]),
    .quanta(rx_pfc_quanta[3*`MFC_QW +: `MFC_QW]),
    .ack_in(rx_prio_pause_ack_in[3]),
    .req_out(rx_prio_pause_req_out[3])
  );

  // Priority 4 receive pause
  mfc_prio_pause u_prio4 (
    .clk(clk),
    .rstn(rstn),
    .load(prio_load[4]),
    .quanta(rx_pfc_quanta[4*`MFC_QW +: `MFC_QW]),
    .ack_in(rx_prio_pause_ack_in[4]),
    .req_out(rx_prio_pause_req_out[4])
  );

  // Priority 5 receive pause
  mfc_prio_pause u_prio5 (
    .clk(clk),
    .rstn(rstn),
    .load(prio_load[5]),
    .quanta(rx_pfc_quanta[5*`MFC_QW +: `MFC_QW]),
    .ack_in(rx_prio_pause_ack_in[5]),
    .req_out(rx_prio_pause_req_out[5])
  );

  // Priority 6 receive pause
  mfc_prio_pause u_prio6 (
    .clk(clk),
    .rstn(rstn),
    .load(prio_load[6]),
    .quanta(rx_pfc_quanta[6*`MFC_QW +: `MFC_QW]),
    .ack_in(rx_prio_pause_ack_in[6]),
    .req_out(rx_prio_pause_req_out[6])
  );

  // Priority 7 receive pause
  mfc_prio_pause u_prio7 (
    .clk(clk),
    .rstn(rstn),
    .load(prio_load[7]),
    .quanta(rx_pfc_quanta[7*`MFC_QW +: `MFC_QW]),
    .ack_in(rx_prio_pause_ack_in[7]),
    .req_out(rx_prio_pause_req_out[7])
  );

endmodule
`default_nettype wire

// File: inc/mfc_map.vh
// Constants for the MAC flow-control request block
`ifndef MFC_MAP_VH
`define MFC_MAP_VH

// Number of priorities and widths
`define MFC_NPRIO 8
`define MFC_QW 16
`define MFC_QALL 128

// One pause quantum is 512 bit times at 10 Gb/s, held in picoseconds
`define MFC_QUANTUM_PS 51200
`define MFC_CLK_PS 4000
// Least time, so rounded up to whole cycles
`define MFC_QUANTUM_CYC ((`MFC_QUANTUM_PS + `MFC_CLK_PS - 1) / `MFC_CLK_PS)
`define MFC_PRE_W 4

// Frame kinds on the transmit request
`define MFC_KIND_PAUSE 1'h0
`define MFC_KIND_PFC 1'h1

// Per-priority receive pause states
`define MFC_ST_IDLE 2'h0
`define MFC_ST_WAIT 2'h1
`define MFC_ST_RUN 2'h2

// Reset values
`define MFC_Q_ZERO 16'h0000
`define MFC_V_ZERO 8'h00

`endif

// File: rtl/mfc_prio_pause.v
// Receive pause request and quanta timer for one priority
`timescale 1ns/1ps
`default_nettype none
`include "mfc_map.vh"

module mfc_prio_pause (
  input wire clk,
  input wire rstn,
  input wire load,
  input wire [`MFC_QW-1:0] quanta,
  input wire ack_in,
  output reg req_out
);

  // Prescaler end point, cut to the counter width on purpose
  localparam integer PRE_LAST_INT = `MFC_QUANTUM_CYC - 1;
  localparam [`MFC_PRE_W-1:0] PRE_LAST = PRE_LAST_INT[`MFC_PRE_W-1:0];
  localparam [`MFC_PRE_W-1:0] PRE_ZERO = 4'h0;
  localparam [`MFC_QW-1:0] Q_ONE = 16'h0001;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`MFC_QW-1:0] quanta_reg;
  reg [`MFC_QW-1:0] quanta_next;
  reg [`MFC_PRE_W-1:0] pre_reg;
  reg [`MFC_PRE_W-1:0] pre_next;

  // A fresh frame reloads at any time; a zero value releases the pause at once
  always @* begin
    state_next = state_reg;
    quanta_next = quanta_reg;
    pre_next = pre_reg;
    if (load) begin
      quanta_next = quanta;
      pre_next = PRE_ZERO;
      state_next = (quanta == `MFC_Q_ZERO) ? `MFC_ST_IDLE : `MFC_ST_WAIT;
    end else begin
      case (state_reg)
        `MFC_ST_IDLE: begin
          state_next = `MFC_ST_IDLE;
        end
        `MFC_ST_WAIT: begin
          // Quanta stay frozen until the FIFO acknowledges
          if (ack_in) begin
            state_next = `MFC_ST_RUN;
          end
        end
        `MFC_ST_RUN: begin
          // Once acknowledged the timer runs to the end even if ack drops
          if (pre_reg == PRE_LAST) begin
            pre_next = PRE_ZERO;
            if (quanta_reg == Q_ONE) begin
              quanta_next = `MFC_Q_ZERO;
              state_next = `MFC_ST_IDLE;
            end else begin
              quanta_next = quanta_reg - Q_ONE;
            end
          end else begin
            pre_next = pre_reg + 4'h1;
          end
        end
        default: begin
          state_next = `MFC_ST_IDLE;
        end
      endcase
    end
  end

  // Request held from capture until the quanta have expired
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= `MFC_ST_IDLE;
      quanta_reg <= `MFC_Q_ZERO;
      pre_reg <= PRE_ZERO;
      req_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      quanta_reg <= quanta_next;
      pre_reg <= pre_next;
      req_out <= (state_next != `MFC_ST_IDLE);
    end
  end

endmodule
`default_nettype wire

// File: sim/mfc_peer.sv
// Far-side model: transmit engine ready and priority RX FIFO acknowledges
`timescale 1ns/1ps
`default_nettype none
module mfc_peer (
  input wire logic clk,
  input wire logic slow,
  input wire logic [7:0] req,
  output logic [7:0] ack,
  output logic ready
);
  logic [23:0] d = 24'h000000;
  logic [1:0] ph = 2'h0;
  // Request history for late acknowledges, phase for a stalling engine
  always @(posedge clk) begin
    d <= {d[15:0], req};
    ph <= ph + 2'h1;
  end
  // Slow FIFOs answer three cycles late; otherwise the handshake is tied high
  assign ack = slow ? d[23:16] : 8'hFF;
  assign ready = !slow || ph == 2'h3;
endmodule
`default_nettype wire

// File: sim/mfc_flow_ctrl_checker.sv
// Assertion checker for the flow-control request block
`timescale 1ns/1ps
`default_nettype none
module mfc_checker (
  input wire clk, input wire rstn, input wire pause_req_valid, input wire [15:0] pause_value,
  input wire [7:0] tx_prio_pause_req_in, input wire tx_fc_frame_valid,
  input wire tx_fc_frame_ready, input wire tx_fc_frame_kind, input wire [15:0] tx_fc_pause_time,
  input wire [7:0] tx_fc_class_enable, input wire rx_pfc_frame_valid,
  input wire [7:0] rx_pfc_class_enable, input wire [127:0] rx_pfc_quanta,
  input wire [7:0] rx_prio_pause_req_out, input wire [7:0] rx_prio_pause_ack_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic acked_reg;
  // Acknowledge seen for the value loaded last; only a frame for priority 0 restarts the wait
  always @(posedge clk or negedge rstn)
    if (!rstn) acked_reg <= 1'b0;
    else acked_reg <= !(rx_pfc_frame_valid && rx_pfc_class_enable[0]) && (acked_reg
      || rx_prio_pause_req_out[0] && rx_prio_pause_ack_in[0]);
  a_pause_frame: assert property ($rose(pause_req_valid) && !tx_fc_frame_valid
    && $past(tx_prio_pause_req_in) == $past(tx_prio_pause_req_in, 2) |-> ##2 tx_fc_frame_valid
    && !tx_fc_frame_kind && tx_fc_pause_time == $past(pause_value, 2)) else $error("bad pause");
  a_frame_hold: assert property (tx_fc_frame_valid && !tx_fc_frame_ready |=>
    tx_fc_frame_valid && $stable({tx_fc_frame_kind, tx_fc_pause_time, tx_fc_class_enable}))
    else $error("frame moved");
  a_frame_class: assert property (tx_fc_frame_valid |-> tx_fc_frame_kind
    == (tx_fc_class_enable != 8'h00)) else $error("bad class");
  a_rx_req: assert property (rx_pfc_frame_valid && rx_pfc_class_enable[0]
    && rx_pfc_quanta[15:0] != 16'h0000 |=> rx_prio_pause_req_out[0]) else $error("no req 0");
  a_rx_top: assert property (rx_pfc_frame_valid && rx_pfc_class_enable[7]
    && rx_pfc_quanta[127:112] != 16'h0000 |=> rx_prio_pause_req_out[7]) else $error("no req 7");
  a_rx_zero: assert property (rx_pfc_frame_valid && rx_pfc_class_enable[0]
    && rx_pfc_quanta[15:0] == 16'h0000 |=> !rx_prio_pause_req_out[0]) else $error("zero req");
  a_wait_ack: assert property (rx_prio_pause_req_out[0] && !acked_reg
    && !rx_prio_pause_ack_in[0] && !rx_pfc_frame_valid |=> rx_prio_pause_req_out[0])
    else $error("early count");
  a_req_idle: assert property (!rx_prio_pause_req_out[1] && !(rx_pfc_frame_valid
    && rx_pfc_class_enable[1]) |=> !rx_prio_pause_req_out[1]) else $error("stray req 1");
  c_pause: cover property (tx_fc_frame_valid && tx_fc_frame_ready && !tx_fc_frame_kind);
  c_pfc: cover property (tx_fc_frame_valid && tx_fc_frame_ready && tx_fc_frame_kind);
  c_rx_end: cover property ($fell(rx_prio_pause_req_out[0]));
endmodule
bind mfc_flow_ctrl mfc_checker u_chk (.*);
`default_nettype wire

// File: sim/mfc_flow_ctrl_bench.sv
// Self-checking bench for the flow-control request block
`timescale 1ns/1ps
`default_nettype none
module mfc_flow_ctrl_bench;
  logic clk = 1'b0, rstn = 1'b0, pv = 1'b0, slow = 1'b0, rfv = 1'b0, rdy, kind, fv;
  logic [15:0] pval = 16'h0000, pq = 16'h0000, tm;
  logic [7:0] preq = 8'h00, rcls = 8'h00, req, ack, cls;
  logic [127:0] rq = 128'h0;
  logic [24:0] expq[$];
  integer err_count = 0, checks = 0, seed = 32'h9db5b5f8, i, k, e;
  mfc_flow_ctrl DUT (.clk(clk), .rstn(rstn), .pause_req_valid(pv), .pause_value(pval),
    .tx_prio_pause_req_in(preq), .pfc_tx_quanta(pq), .tx_fc_frame_valid(fv),
    .tx_fc_frame_ready(rdy), .tx_fc_frame_kind(kind), .tx_fc_pause_time(tm),
    .tx_fc_class_enable(cls), .rx_pfc_frame_valid(rfv), .rx_pfc_class_enable(rcls),
    .rx_pfc_quanta(rq), .rx_prio_pause_req_out(req), .rx_prio_pause_ack_in(ack));
  mfc_peer peer (.clk(clk), .slow(slow), .req(req), .ack(ack), .ready(rdy));
  always #2 clk = ~clk;
  task automatic chk(input string nm, input logic [24:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic go(input integer c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Owed frames in request order; an unowed frame compares against all ones
  // Sampled mid-cycle, where the handshake seen by the next rising edge has settled
  always @(negedge clk)
    if (fv === 1'b1 && rdy === 1'b1)
      chk("frame", {kind, tm, cls}, expq.size() ? expq.pop_front() : 25'h1FFFFFF);
  // Watchdog sized well above both loops
  initial begin
    #40000;
    err_count++;
    end_of_test;
  end
  // Pause then priority frame per pass, engine stalling in the second half
  initial begin
    go(3);
    rstn = 1'b1;
    chk("idle", {fv, req}, 25'h0);
    for (i = 0; i < 16; i++) begin
      slow = i[3];
      pval = 16'($random(seed));
      pq = 16'($random(seed));
      pv = 1'b1;
      expq.push_back({1'b0, pval, 8'h00});
      go(1);
      preq = 8'h01 << i[2:0];
      expq.push_back({1'b1, pq, preq});
      go(3);
      {pv, preq} = 9'h000;
      go(1); // Low level must be sampled, or the next request is no fresh edge
      for (k = 0; k < 60 && expq.size(); k++) go(1);
      chk("owed", 25'(expq.size()), 25'h0);
      $display("tx test %0d done", i);
    end
    // Receive pause per priority; slow FIFOs acknowledge three cycles late
    for (i = 0; i < 16; i++) begin
      slow = i[3];
      rq = {$random(seed), $random(seed), $random(seed), $random(seed)} & {8{16'h0003}};
      rcls = 8'h01 << i[2:0];
      rfv = 1'b1;
      go(1);
      {rfv, rcls} = 9'h000;
      chk("others", req & ~(8'h01 << i[2:0]), 25'h0);
      e = rq[16 * i[2:0] +: 16];
      e = e ? e * 13 + 1 + 3 * slow : 0;
      for (k = 0; k < 300 && req[i[2:0]] === 1'b1; k++) go(1);
      chk("span", k >= e && k <= e + 1, 25'h1);
      $display("rx test %0d done", i);
    end
    end_of_test;
  end
endmodule
`default_nettype wire
